// ===== hw/prse_receiver.v
// PCM highway receive slot capture, expansion and settings logic
`timescale 1ns/1ps
`include "prse_map.vh"
module prse_receiver (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Highway pins
	input wire pcm_bit_clock_in,
	input wire frame_sync_pulse_in,
	input wire receive_port_a_in,
	input wire receive_port_b_in,
	// Signaling pin
	output wire signaling_data_out,
	output wire signaling_oe_out,
	// Slot settings
	input wire [6:0] receive_slot_number_in,
	input wire [2:0] receive_bit_offset_in,
	input wire port_b_select_in,
	input wire [1:0] coding_mode_in,
	input wire channel_active_in,
	// Signaling settings and sources
	input wire signaling_mode_select_in,
	input wire robbed_bit_enable_in,
	input wire debounced_hook_input_in,
	input wire second_detect_input_in,
	input wire alternate_detect_input_in,
	input wire alternate_detect_select_in,
	input wire clock_fail_flag_in,
	// Scaling and defaults
	input wire [4:0] impedance_scaling_gain_in,
	input wire use_defaults_in,
	// Coefficient memory port
	input wire coef_write_in,
	input wire coef_read_in,
	input wire [2:0] coef_addr_in,
	input wire [7:0] coef_wdata_in,
	output wire [7:0] coef_rdata_out,
	output wire coef_rvalid_out,
	// Received samples
	output wire [15:0] rx_sample_out,
	output wire rx_sample_valid_out,
	output wire robbed_frame_out,
	// Effective coefficients
	output wire [5:0] scaling_gain_out,
	output wire scaling_cutoff_out,
	output wire digital_loopback_out,
	output wire [15:0] transmit_digital_gain_out,
	output wire [15:0] receive_digital_loss_out,
	output wire transmit_analog_gain_out,
	output wire receive_analog_loss_out,
	output wire equalizers_unity_out,
	output wire balance_zero_out
);
	// Pin synchronisers
	reg clk_s1_q;
	reg clk_s2_q;
	reg clk_s3_q;
	reg fs_s1_q;
	reg fs_s2_q;
	reg da_s1_q;
	reg da_s2_q;
	reg db_s1_q;
	reg db_s2_q;
	// Frame timing
	reg fs_prev_q;
	reg [1:0] fs_run_q;
	reg last_two_q;
	reg robbed_q;
	reg [9:0] bit_cnt_q;
	// Capture
	reg [15:0] shift_q;
	reg done_q;
	reg [15:0] word_q;
	reg lin_q;
	reg half_q;
	reg alaw_q;
	reg [15:0] sample_q;
	reg valid_q;
	// Signaling drive
	reg sig_bit_q;
	reg sig_oe_q;
	// Coefficients
	reg [7:0] coef_mem [0:7];
	reg [7:0] coef_rdata_q;
	reg coef_rvalid_q;
	reg [5:0] gain_q;
	reg cutoff_q;
	reg loop_q;
	reg [15:0] txg_q;
	reg [15:0] rxl_q;
	reg ax_q;
	reg ar_q;
	reg equ_q;
	reg bal_q;

	wire fall;
	wire fs_start;
	wire fs_end;
	wire is_lin;
	wire is_mu;
	wire companded;
	wire din;
	wire [9:0] idx;
	wire [10:0] start_pos;
	wire [10:0] diff;
	wire [10:0] dlen;
	wire in_data;
	wire in_sig;
	wire last_bit;
	wire len_two;
	wire [7:0] sig_byte;
	wire [15:0] exp_sample;
	wire [4:0] impedance_scaling_gain;

	// Two flip-flops on every pin before use
	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
			fs_s1_q <= 1'b0;
			fs_s2_q <= 1'b0;
			da_s1_q <= 1'b0;
			da_s2_q <= 1'b0;
			db_s1_q <= 1'b0;
			db_s2_q <= 1'b0;
		end
		else
		begin
			clk_s1_q <= pcm_bit_clock_in;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			fs_s1_q <= frame_sync_pulse_in;
			fs_s2_q <= fs_s1_q;
			da_s1_q <= receive_port_a_in;
			da_s2_q <= da_s1_q;
			db_s1_q <= receive_port_b_in;
			db_s2_q <= db_s1_q;
		end
	end

	// Falling bit clock edge samples sync and data
	assign fall = clk_s3_q & ~clk_s2_q;
	assign fs_start = fall & fs_s2_q & ~fs_prev_q;
	assign fs_end = fall & ~fs_s2_q & fs_prev_q;
	assign is_lin = (coding_mode_in == `PRSE_CODE_LINEAR);
	assign is_mu = (coding_mode_in == `PRSE_CODE_MULAW);
	assign companded = ~is_lin;
	assign din = port_b_select_in ? db_s2_q : da_s2_q;

	// Bit position within frame, zero at sync
	assign idx = fs_start ? `PRSE_RST_CNT : bit_cnt_q;
	// Slot start: slot times eight plus offset
	assign start_pos = ({4'h0, receive_slot_number_in} << `PRSE_SLOT_SHIFT)
		+ {8'h00, receive_bit_offset_in};
	// Beyond the frame end the slot is never reached; host avoids it
	assign diff = {1'b0, idx} - start_pos;
	assign dlen = is_lin ? `PRSE_LEN_WORD : `PRSE_LEN_BYTE;
	assign in_data = (diff < dlen);
	assign last_bit = (diff == (dlen - 11'h001));
	assign in_sig = signaling_mode_select_in & companded
		& (diff >= `PRSE_LEN_BYTE) & (diff < `PRSE_LEN_WORD);
	assign len_two = (fs_run_q == `PRSE_FS_TWO);

	// Signaling byte layout
	assign sig_byte = {debounced_hook_input_in,
		alternate_detect_select_in ? alternate_detect_input_in : second_detect_input_in,
		3'h0, clock_fail_flag_in, 2'h0};

	// Sync length and robbed frame detection
	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			fs_prev_q <= 1'b0;
			fs_run_q <= 2'h0;
			last_two_q <= 1'b0;
			robbed_q <= 1'b0;
			bit_cnt_q <= `PRSE_RST_CNT;
		end
		else if (fall)
		begin
			fs_prev_q <= fs_s2_q;
			bit_cnt_q <= idx + 10'h001;
			if (fs_start)
				fs_run_q <= 2'h1;
			else if (fs_s2_q && fs_run_q != 2'h3)
				fs_run_q <= fs_run_q + 2'h1;
			// High two edges then low on the third
			if (fs_end)
			begin
				robbed_q <= robbed_bit_enable_in & is_mu & len_two
					& ~last_two_q;
				last_two_q <= len_two;
			end
		end
	end

	// Shift in slot bits, MSB first
	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			shift_q <= `PRSE_RST_SAMPLE;
			done_q <= 1'b0;
			word_q <= `PRSE_RST_SAMPLE;
			lin_q <= 1'b0;
			half_q <= 1'b0;
			alaw_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (fall && in_data)
			begin
				shift_q <= {shift_q[14:0], din};
				if (last_bit)
				begin
					done_q <= channel_active_in;
					word_q <= {shift_q[14:0], din};
					lin_q <= is_lin;
					alaw_q <= (coding_mode_in == `PRSE_CODE_ALAW);
					half_q <= robbed_q & is_mu;
				end
			end
		end
	end

	// Expander for companded bytes
	prse_expander u_exp (
		.code_in(word_q[7:0]),
		.alaw_in(alaw_q),
		.half_lsb_in(half_q),
		.sample_out(exp_sample)
	);

	// Linear data bypasses the expander
	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sample_q <= `PRSE_RST_SAMPLE;
			valid_q <= 1'b0;
		end
		else
		begin
			valid_q <= done_q;
			if (done_q)
				sample_q <= lin_q ? word_q : exp_sample;
		end
	end

	// Signaling byte follows data byte directly, also in standby
	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sig_bit_q <= 1'b0;
			sig_oe_q <= 1'b0;
		end
		else if (fall)
		begin
			sig_oe_q <= in_sig;
			sig_bit_q <= in_sig & sig_byte[~diff[2:0]];
		end
	end

	// Programmable coefficient memory, not reset
	always @(posedge clk_in)
	begin
		if (coef_write_in)
			coef_mem[coef_addr_in] <= coef_wdata_in;
	end

	// Reads see memory only, never the fixed defaults
	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			coef_rdata_q <= 8'h00;
			coef_rvalid_q <= 1'b0;
		end
		else
		begin
			coef_rvalid_q <= coef_read_in;
			if (coef_read_in)
				coef_rdata_q <= coef_mem[coef_addr_in];
		end
	end

	// Defaults force scaling cut off
	assign impedance_scaling_gain = use_defaults_in ? `PRSE_IMPEDANCE_SCALING_GAIN_CUTOFF : impedance_scaling_gain_in;

	// Effective scaling and coefficients
	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			gain_q <= 6'h00;
			cutoff_q <= 1'b1;
			loop_q <= 1'b0;
			txg_q <= `PRSE_DEF_TX_GAIN;
			rxl_q <= `PRSE_DEF_RX_LOSS;
			ax_q <= 1'b0;
			ar_q <= 1'b0;
			equ_q <= 1'b1;
			bal_q <= 1'b1;
		end
		else
		begin
			cutoff_q <= (impedance_scaling_gain == `PRSE_IMPEDANCE_SCALING_GAIN_CUTOFF);
			loop_q <= (impedance_scaling_gain == `PRSE_IMPEDANCE_SCALING_GAIN_LOOP);
			if (impedance_scaling_gain == `PRSE_IMPEDANCE_SCALING_GAIN_CUTOFF || impedance_scaling_gain == `PRSE_IMPEDANCE_SCALING_GAIN_LOOP)
				gain_q <= 6'h00;
			else
				gain_q <= {1'b0, impedance_scaling_gain} - `PRSE_IMPEDANCE_SCALING_GAIN_BIAS;
			if (use_defaults_in)
			begin
				txg_q <= `PRSE_DEF_TX_GAIN;
				rxl_q <= `PRSE_DEF_RX_LOSS;
				ax_q <= 1'b0;
				ar_q <= 1'b0;
				equ_q <= 1'b1;
				bal_q <= 1'b1;
			end
			else
			begin
				txg_q <= {coef_mem[`PRSE_COEF_TXG_HI], coef_mem[`PRSE_COEF_TXG_LO]};
				rxl_q <= {coef_mem[`PRSE_COEF_RXL_HI], coef_mem[`PRSE_COEF_RXL_LO]};
				ax_q <= coef_mem[`PRSE_COEF_ANALOG][0];
				ar_q <= coef_mem[`PRSE_COEF_ANALOG][1];
				equ_q <= coef_mem[`PRSE_COEF_FILT][0];
				bal_q <= coef_mem[`PRSE_COEF_FILT][1];
			end
		end
	end

	// Output drive
	assign signaling_data_out = sig_bit_q;
	assign signaling_oe_out = sig_oe_q;
	assign coef_rdata_out = coef_rdata_q;
	assign coef_rvalid_out = coef_rvalid_q;
	assign rx_sample_out = sample_q;
	assign rx_sample_valid_out = valid_q;
	assign robbed_frame_out = robbed_q;
	assign scaling_gain_out = gain_q;
	assign scaling_cutoff_out = cutoff_q;
	assign digital_loopback_out = loop_q;
	assign transmit_digital_gain_out = txg_q;
	assign receive_digital_loss_out = rxl_q;
	assign transmit_analog_gain_out = ax_q;
	assign receive_analog_loss_out = ar_q;
	assign equalizers_unity_out = equ_q;
	assign balance_zero_out = bal_q;
endmodule // prse_receiver

// ===== hw/prse_map.vh
// Constants of the PCM receive slot expander
// What this block does
// - Receive slot number is seven bits, addressing up to 128 byte slots.
// - Frame sync marks receive slot zero; all slots count from it.
// - Three-bit bit offset delays the assigned slot by zero to seven bit clocks.
// - With a fractional frame remainder below the offset, the last slot is unusable.
// - Linear mode bypasses expansion and spans two slots; companded uses one.
// - Receive data comes from port a or port b as selected.
// - Linear samples are 16-bit two's complement, sign bit first.
// - A-law coding applies alternate bit inversion.
// - Scaling gain equals 0.0625 times code minus 16.
// - Scaling code zero gives zero gain, cutting the path off.
// - Scaling code 10000 gives unity digital loopback, analog input ignored.
// - Signaling mode adds a byte: hook bit 7, detect bit 6, clock fail bit 2.
// - Signaling bit 7 follows data bit 0 with no gap.
// - Signaling slot stays driven while the channel is in standby.
// - Robbed-bit handling touches only the mu-law receive path.
// - In robbed frames the received LSB is replaced by half its weight.
// - Robbed frame: enable set, mu-law, two-cycle sync, previous sync not two.
// - Frame sync is sampled on falling bit clock edges to measure its length.
// - Defaults give fixed gains, unity equalizers, zero filters, scaling cut off.
// - Coefficient reads return programmable memory only, never defaults.
`ifndef PRSE_MAP_VH
`define PRSE_MAP_VH
// Coding modes
`define PRSE_CODE_ALAW 2'h0
`define PRSE_CODE_MULAW 2'h1
`define PRSE_CODE_LINEAR 2'h2
// Capture lengths in bits
`define PRSE_LEN_BYTE 11'h008
`define PRSE_LEN_WORD 11'h010
// Slot field position: slot number times eight bits
`define PRSE_SLOT_SHIFT 3
// Frame sync length that marks a robbed frame
`define PRSE_FS_TWO 2'h2
// Scaling gain special codes and bias
`define PRSE_IMPEDANCE_SCALING_GAIN_CUTOFF 5'h00
`define PRSE_IMPEDANCE_SCALING_GAIN_LOOP 5'h10
`define PRSE_IMPEDANCE_SCALING_GAIN_BIAS 6'h10
// Companding constants
`define PRSE_ALAW_MASK 8'h55
`define PRSE_MU_BIAS 16'h0084
`define PRSE_A_BIAS 16'h0108
// Default coefficients, gains in milli-dB
`define PRSE_DEF_TX_GAIN 16'h1770
`define PRSE_DEF_RX_LOSS 16'hdce8
// Coefficient memory layout
`define PRSE_COEF_TXG_LO 3'h0
`define PRSE_COEF_TXG_HI 3'h1
`define PRSE_COEF_RXL_LO 3'h2
`define PRSE_COEF_RXL_HI 3'h3
`define PRSE_COEF_ANALOG 3'h4
`define PRSE_COEF_FILT 3'h5
// Reset values
`define PRSE_RST_SAMPLE 16'h0000
`define PRSE_RST_CNT 10'h000
`endif

// ===== hw/prse_expander.v
// Companded byte to linear sample expander
`timescale 1ns/1ps
`include "prse_map.vh"
module prse_expander (
	// Code in
	input wire [7:0] code_in,
	input wire alaw_in,
	input wire half_lsb_in,
	// Linear out
	output wire [15:0] sample_out
);
	wire [7:0] inv;
	wire sign;
	wire [2:0] ex;
	wire [3:0] man;
	wire [15:0] m0;
	wire [15:0] m1;
	wire [16:0] sum;
	wire [15:0] mag;

	// Magnitude for one mantissa value
	function [15:0] mag_of;
		input a;
		input [2:0] e;
		input [3:0] m;
		reg [15:0] t;
		begin
			t = 16'h0000;
			if (a)
			begin
				if (e == 3'h0)
					t = {8'h00, m, 4'h8};
				else
					t = ({8'h00, m, 4'h0} + `PRSE_A_BIAS) << (e - 3'h1);
			end
			else
				t = (({9'h000, m, 3'h0} + `PRSE_MU_BIAS) << e) - `PRSE_MU_BIAS;
			mag_of = t;
		end
	endfunction

	// Alternate bit inversion for A-law, full inversion for mu-law
	assign inv = alaw_in ? (code_in ^ `PRSE_ALAW_MASK) : ~code_in;
	assign sign = alaw_in ? ~inv[7] : inv[7];
	assign ex = inv[6:4];
	assign man = inv[3:0];
	assign m0 = mag_of(alaw_in, ex, {man[3:1], 1'b0});
	assign m1 = mag_of(alaw_in, ex, {man[3:1], 1'b1});
	// Half LSB weight is the mean of both LSB values
	assign sum = {1'b0, m0} + {1'b0, m1};
	assign mag = half_lsb_in ? sum[16:1] : mag_of(alaw_in, ex, man);
	assign sample_out = sign ? (16'h0000 - mag) : mag;
endmodule // prse_expander

// ===== tb/prse_checker.sv
// Port assertions for the receive slot expander
`timescale 1ns/1ps
`include "prse_map.vh"
module prse_checker (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Settings
	input wire [1:0] coding_mode_in,
	input wire channel_active_in,
	input wire robbed_bit_enable_in,
	input wire [4:0] impedance_scaling_gain_in,
	input wire use_defaults_in,
	input wire coef_read_in,
	// Outputs
	input wire signaling_oe_out,
	input wire coef_rvalid_out,
	input wire rx_sample_valid_out,
	input wire robbed_frame_out,
	input wire [5:0] scaling_gain_out,
	input wire scaling_cutoff_out,
	input wire digital_loopback_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// Sample strobe and standby
	property p_valid;
		rx_sample_valid_out |=> !rx_sample_valid_out;
	endproperty
	a_valid: assert property (p_valid) else $error("long strobe");
	property p_standby;
		(!channel_active_in) [*3] |-> !rx_sample_valid_out;
	endproperty
	a_standby: assert property (p_standby) else $error("standby sample");
	// Scaling codes and defaults
	property p_cut;
		use_defaults_in || impedance_scaling_gain_in == `PRSE_IMPEDANCE_SCALING_GAIN_CUTOFF
			|=> scaling_cutoff_out && !digital_loopback_out;
	endproperty
	a_cut: assert property (p_cut) else $error("no cutoff");
	property p_loop;
		!use_defaults_in && impedance_scaling_gain_in == `PRSE_IMPEDANCE_SCALING_GAIN_LOOP
			|=> digital_loopback_out && scaling_gain_out == 6'h00;
	endproperty
	a_loop: assert property (p_loop) else $error("no loopback");
	property p_gain;
		!use_defaults_in && impedance_scaling_gain_in != `PRSE_IMPEDANCE_SCALING_GAIN_CUTOFF
			&& impedance_scaling_gain_in != `PRSE_IMPEDANCE_SCALING_GAIN_LOOP
			|=> scaling_gain_out == {1'b0, $past(impedance_scaling_gain_in)} - `PRSE_IMPEDANCE_SCALING_GAIN_BIAS;
	endproperty
	a_gain: assert property (p_gain) else $error("bad gain");
	// Coefficient read answer
	property p_rvalid;
		coef_rvalid_out == $past(coef_read_in);
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("bad read strobe");
	// Signaling and robbed frames
	property p_siglin;
		(coding_mode_in == `PRSE_CODE_LINEAR) [*8] |-> !signaling_oe_out;
	endproperty
	a_siglin: assert property (p_siglin) else $error("linear signaling");
	property p_rob;
		$rose(robbed_frame_out) |-> robbed_bit_enable_in && coding_mode_in == `PRSE_CODE_MULAW;
	endproperty
	a_rob: assert property (p_rob) else $error("bad robbed frame");
endmodule // prse_checker
bind prse_receiver prse_checker chk_u (.clk_in, .rst_in, .coding_mode_in, .channel_active_in,
	.robbed_bit_enable_in, .impedance_scaling_gain_in, .use_defaults_in, .coef_read_in,
	.signaling_oe_out, .coef_rvalid_out, .rx_sample_valid_out, .robbed_frame_out,
	.scaling_gain_out, .scaling_cutoff_out, .digital_loopback_out);

// ===== tb/prse_hwy_model.sv
// Highway partner: bit clock, frame sync and both data lines
`timescale 1ns/1ps
module prse_hwy_model (
	// Frame contents
	input wire clk_in,
	input wire [31:0] frame_a_in,
	input wire [31:0] frame_b_in,
	input wire [1:0] fs_len_in,
	// Highway pins
	output logic bclk_out,
	output logic fs_out,
	output logic da_out,
	output logic db_out
);
	logic [2:0] ph_q = 3'h0;
	logic [4:0] idx_q = 5'h0;
	logic [31:0] fa_q = 32'h0;
	logic [31:0] fb_q = 32'h0;
	logic [1:0] fl_q = 2'h0;
	wire [4:0] nx = idx_q + 5'h1;
	initial {bclk_out, fs_out, da_out, db_out} = 4'h0;
	// Four whole slots, bit clock of eight system clocks; lines change on its rise
	always @(posedge clk_in)
	begin
		ph_q <= ph_q + 3'h1;
		if (ph_q == 3'h3)
			bclk_out <= 1'b0;
		if (ph_q == 3'h7)
		begin
			bclk_out <= 1'b1;
			idx_q <= nx;
			fs_out <= {3'h0, fl_q} > nx;
			da_out <= fa_q[~nx];
			db_out <= fb_q[~nx];
			if (nx == 5'h1f)
			begin
				fa_q <= frame_a_in;
				fb_q <= frame_b_in;
				fl_q <= fs_len_in;
			end
		end
	end
endmodule // prse_hwy_model

// ===== tb/tb_top.sv
// Self-checking bench for the receive slot expander
`timescale 1ns/1ps
`include "prse_map.vh"
module tb_top;
	logic clk_in, rst_in, bclk, fs, da, db, psel, act, signaling_mode_select, robbed_bit_enable, hook, det2, alt, altsel;
	logic clock_fail_flag, defs, cw, cr, sd, soe, crv, rv, rob, cut, lpb, txa, rxa, equ, bal, seen;
	logic [1:0] mode, fl;
	logic [2:0] offs, caddr;
	logic [4:0] impedance_scaling_gain;
	logic [5:0] sg;
	logic [6:0] slot;
	logic [7:0] cwd, crd, sig_q;
	logic [15:0] so, smp, txg, rxl, s1, s2;
	logic [31:0] pa, pb;
	int miscompares, checked, sig_n;
	prse_hwy_model hwy_u (.clk_in(clk_in), .frame_a_in(pa), .frame_b_in(pb), .fs_len_in(fl),
		.bclk_out(bclk), .fs_out(fs), .da_out(da), .db_out(db));
	prse_receiver dut_u (.clk_in(clk_in), .rst_in(rst_in), .pcm_bit_clock_in(bclk),
		.frame_sync_pulse_in(fs), .receive_port_a_in(da), .receive_port_b_in(db),
		.signaling_data_out(sd), .signaling_oe_out(soe), .receive_slot_number_in(slot),
		.receive_bit_offset_in(offs), .port_b_select_in(psel), .coding_mode_in(mode),
		.channel_active_in(act), .signaling_mode_select_in(signaling_mode_select), .robbed_bit_enable_in(robbed_bit_enable),
		.debounced_hook_input_in(hook), .second_detect_input_in(det2),
		.alternate_detect_input_in(alt), .alternate_detect_select_in(altsel),
		.clock_fail_flag_in(clock_fail_flag), .impedance_scaling_gain_in(impedance_scaling_gain), .use_defaults_in(defs),
		.coef_write_in(cw), .coef_read_in(cr), .coef_addr_in(caddr), .coef_wdata_in(cwd),
		.coef_rdata_out(crd), .coef_rvalid_out(crv), .rx_sample_out(so),
		.rx_sample_valid_out(rv), .robbed_frame_out(rob), .scaling_gain_out(sg),
		.scaling_cutoff_out(cut), .digital_loopback_out(lpb), .transmit_digital_gain_out(txg),
		.receive_digital_loss_out(rxl), .transmit_analog_gain_out(txa),
		.receive_analog_loss_out(rxa), .equalizers_unity_out(equ), .balance_zero_out(bal));
	// System clock
	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// Shift the signaling pin in two clocks after each bit clock rise
	always @(posedge bclk)
	begin
		repeat (2) @(posedge clk_in);
		#1;
		if (soe === 1'b1)
		begin
			sig_q = {sig_q[6:0], sd};
			sig_n++;
		end
	end
	// Compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Verdict and end of run
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Load a frame at one sync, then watch the frame that carries it
	task automatic frame(input logic [31:0] a, input logic [1:0] len);
		@(posedge fs);
		#1;
		pa = a;
		pb = ~a;
		fl = len;
		@(posedge fs);
		sig_n = 0;
		seen = 1'b0;
		repeat (250)
		begin
			@(posedge clk_in);
			#1;
			if (rv === 1'b1)
			begin
				seen = 1'b1;
				smp = so;
			end
		end
	endtask
	// Apply one scaling code and check the effective outputs
	task automatic sc(input logic [4:0] c, input logic [5:0] g, input logic [1:0] f);
		impedance_scaling_gain = c;
		repeat (2) @(posedge clk_in);
		#1;
		check({sg, cut, lpb}, {g, f});
	endtask
	// Scaling codes, default set and coefficient readback
	task automatic t_scale;
		sc(5'h00, 6'h00, 2'b10);
		sc(5'h01, 6'h31, 2'b00);
		sc(5'h10, 6'h00, 2'b01);
		sc(5'h1f, 6'h0f, 2'b00);
		defs = 1'b1;
		cw = 1'b1;
		caddr = 3'h5;
		cwd = 8'h02;
		@(posedge clk_in);
		#1;
		cw = 1'b0;
		cr = 1'b1;
		@(posedge clk_in);
		#1;
		cr = 1'b0;
		// Read answer stands for one cycle only, right after the read edge
		check({crv, crd}, 9'h102);
		check({cut, lpb, equ, bal, txa, rxa}, 6'b101100);
		check({txg, rxl}, 32'h1770_dce8);
		defs = 1'b0;
	endtask
	// Linear words from either port at a slot and bit offset
	task automatic t_linear;
		mode = `PRSE_CODE_LINEAR;
		slot = 7'h01;
		offs = 3'h3;
		psel = 1'b1;
		signaling_mode_select = 1'b1;
		frame(~{11'h000, 16'h8123, 5'h00}, 2'h1);
		check({seen, smp, sig_n[3:0]}, 21'h181230);
		psel = 1'b0;
		frame({11'h000, 16'h4c3a, 5'h00}, 2'h1);
		check({seen, smp}, 17'h14c3a);
	endtask
	// Signaling byte in standby and in operation
	task automatic t_signal;
		mode = `PRSE_CODE_MULAW;
		slot = 7'h00;
		offs = 3'h0;
		act = 1'b0;
		{hook, det2, alt, altsel, clock_fail_flag} = 5'b10111;
		frame(32'hff00_0000, 2'h1);
		check({seen, sig_n[3:0], sig_q}, 13'h08c4);
		act = 1'b1;
		altsel = 1'b0;
		frame(32'hff00_0000, 2'h1);
		check({seen, smp, sig_n[3:0], sig_q}, 29'h10000884);
	endtask
	// Robbed frames by sync length, then A-law
	task automatic t_robbed;
		signaling_mode_select = 1'b0;
		robbed_bit_enable = 1'b1;
		frame(32'hfe00_0000, 2'h1);
		s1 = smp;
		check(rob, 1'b0);
		frame(32'hfe00_0000, 2'h2);
		s2 = smp;
		check({rob, s2 > 16'h0000, s2 < s1}, 3'b111);
		frame(32'hfe00_0000, 2'h2);
		check({rob, smp}, {1'b0, s1});
		mode = `PRSE_CODE_ALAW;
		frame(32'hd500_0000, 2'h1);
		s1 = smp;
		frame(32'h8000_0000, 2'h2);
		check({rob, smp > s1}, 2'b01);
	endtask
	// Main sequence
	initial
	begin
		{rst_in, act, fl} = 4'b1101;
		{psel, signaling_mode_select, robbed_bit_enable, hook, det2, alt, altsel, clock_fail_flag, defs, cw, cr} = 11'h000;
		{mode, offs, caddr, impedance_scaling_gain, slot, cwd, sig_q} = 35'h0;
		{pa, pb} = 64'h0;
		miscompares = 0;
		checked = 0;
		sig_n = 0;
		repeat (5) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		t_scale;
		t_linear;
		t_signal;
		t_robbed;
		summarize;
	end
	// Cut a hang short
	initial
	begin
		#2000000;
		miscompares++;
		summarize;
	end
endmodule // tb_top
